// [rtl/nt_cfg_pkg.sv]
// constants for the link-side configuration header tail
// assumes one clock domain; host and preload ports use byte addresses
// Operation
// - window five fully writable only in 64-bit pairing
// - 32-bit pairing: window five low bits zero
// - 64-bit: all bits upper address; all 32 bits writable
// - subsystem codes read-only, preloadable defaults
// - option ROM on one side only
// - ROM on link side by default
// - disabled or foreign ROM reads zero
// - bit 0 is preloadable read-only enable
// - size bit 0: 16 KB, bit 14 writable
// - size bit 1: 32 KB, bit 14 read-only
// - capability pointer 40h, upper bits zero
// - interrupt line byte writable, resets zero
// - interrupt pin 01h, only 00h/01h loadable
// - grant and latency bytes read zero
// - power capability id 01h, next 48h
// - power control, reserved byte, data byte layout
// - map type 00b 32-bit, 10b 64-bit
package nt_cfg_pkg;
   localparam logic [7:0] OFF_WIN5 = 8'h24;
   localparam logic [7:0] OFF_SUBSYS = 8'h2C;
   localparam logic [7:0] OFF_ROM = 8'h30;
   localparam logic [7:0] OFF_CAP_PTR = 8'h34;
   localparam logic [7:0] OFF_INTR = 8'h3C;
   localparam logic [7:0] OFF_PM_CAP = 8'h40;
   localparam logic [7:0] OFF_PM_CTRL = 8'h44;
   localparam logic [1:0] MAP_TYPE_32 = 2'h0;
   localparam logic [1:0] MAP_TYPE_64 = 2'h2;
   localparam logic [31:0] WIN5_UPPER_MASK = 32'hFFF0_0000;
   localparam logic [31:0] ALL_ONES = 32'hFFFF_FFFF;
   localparam logic [31:0] WIN5_RESET = 32'h0000_0000;
   localparam logic [31:0] ROM_MASK_16K = 32'hFFFF_C000;
   localparam logic [31:0] ROM_MASK_32K = 32'hFFFF_8000;
   localparam int ROM_SIZE_BIT = 14;
   localparam logic [31:0] ROM_BASE_RESET = 32'hFFFF_C000;
   localparam logic ROM_ENABLE_RESET = 1'h1;
   // arbitrary neutral identity values
   localparam logic [15:0] SUBSYS_VENDOR_RESET = 16'hA5A5;
   localparam logic [15:0] SUBSYS_DEVICE_RESET = 16'h5A5A;
   localparam logic [7:0] CAP_PTR_RESET = 8'h40;
   localparam logic [7:0] INTR_LINE_RESET = 8'h00;
   localparam logic [7:0] INTR_PIN_NONE = 8'h00;
   localparam logic [7:0] INTR_PIN_RESET = 8'h01;
   localparam logic [7:0] PM_CAP_ID_RESET = 8'h01;
   localparam logic [7:0] PM_NEXT_RESET = 8'h48;
   localparam logic [15:0] PM_CAP_HI_RESET = 16'h0003;
   localparam logic [15:0] PM_CAP_HI_LOADABLE = 16'hF9E7;
   localparam logic [1:0] PS_D0 = 2'h0;
   localparam logic [1:0] PS_D3HOT = 2'h3;
   localparam logic NO_SOFT_RESET_RESET = 1'h1;
   localparam logic [3:0] DSEL_D0_USED = 4'h0;
   localparam logic [3:0] DSEL_D3_USED = 4'h3;
   localparam logic [3:0] DSEL_D0_DISS = 4'h4;
   localparam logic [3:0] DSEL_D3_DISS = 4'h7;
   localparam logic [3:0] DSEL_RESET = 4'h0;
   localparam logic [1:0] SCALE_RESET = 2'h0;
   localparam logic [7:0] PM_DATA_RESET = 8'h00;

   // byte-lane merge limited to the bits a path may change
   function automatic logic [31:0] merge_lanes(input logic [31:0] old_val,
         input logic [31:0] new_val, input logic [3:0] be, input logic [31:0] mask);
      logic [31:0] bm;
      bm = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & mask;
      return (old_val & ~bm) | (new_val & bm);
   endfunction
endpackage

// [rtl/nt_link_config_header_tail.sv]
// upper part of the link-side type 0 header: dwords 24h to 44h
// assumes host config and preload ports are on this clock and
// that control inputs come from registers in the same domain
`timescale 1ns/1ps
`default_nettype none
module nt_link_config_header_tail import nt_cfg_pkg::*; (
   input wire logic clock, // core clock, 125 MHz
   input wire logic rstn, // asynchronous reset, active low
   input wire logic clock_enable, // freezes all state when low
   input wire logic cfg_write, // host config write strobe
   input wire logic cfg_read, // host config read strobe
   input wire logic [7:0] cfg_addr, // dword byte address
   input wire logic [3:0] cfg_byte_en, // host byte enables
   input wire logic [31:0] cfg_wdata, // host write data
   output logic [31:0] cfg_rdata, // read data, registered
   output logic cfg_read_valid, // read data valid pulse
   input wire logic preload_write, // eeprom/i2c load strobe
   input wire logic [7:0] preload_addr, // load dword address
   input wire logic [3:0] preload_byte_en, // load byte enables
   input wire logic [31:0] preload_wdata, // load data
   input wire logic [1:0] window_four_map_type, // window four type
   input wire logic rom_virtual_side, // ROM owned by virtual side
   input wire logic rom_window_disable, // port ROM window off
   input wire logic rom_size_32k, // ROM size select
   output logic [31:0] upper_window_five, // window five as read
   output logic window_pair_64bit, // windows four/five paired
   output logic rom_link_enabled, // link side owns the ROM
   output logic [31:0] rom_window_mask, // ROM decode mask
   output logic [31:0] rom_window_base, // ROM base as read
   output logic [7:0] interrupt_line, // routing byte
   output logic [1:0] power_state // device power state
);
   logic rst_meta;
   logic rst_n_sync;
   logic host_en;
   logic pre_en;
   logic pair_64;
   logic rom_active;
   logic [31:0] win5;
   logic [31:0] win5_mask;
   logic [31:0] win5_read;
   logic [31:0] subsys;
   logic [31:0] rom_base;
   logic [31:0] rom_mask;
   logic rom_enable;
   logic [31:0] rom_read;
   logic [7:0] cap_ptr;
   logic [7:0] intr_line;
   logic [7:0] intr_pin;
   logic [31:0] pm_cap;
   logic [31:0] read_word;
   pm_access_if pm_acc ();

   // reset release through two flops; assertion stays asynchronous
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         rst_meta <= 1'b0;
         rst_n_sync <= 1'b0;
      end else if (clock_enable) begin
         rst_meta <= 1'b1;
         rst_n_sync <= rst_meta;
      end
   end

   assign host_en = clock_enable && cfg_write;
   assign pre_en = clock_enable && preload_write;

   assign pair_64 = (window_four_map_type == MAP_TYPE_64);

   assign win5_mask = pair_64 ? ALL_ONES : WIN5_UPPER_MASK;

   assign win5_read = win5 & win5_mask;

   // window five; in 32-bit mode low bits take neither host nor load
   always_ff @(posedge clock or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         win5 <= WIN5_RESET;
      end else if (host_en || pre_en) begin
         win5 <= merge_lanes(
            merge_lanes(win5, cfg_wdata, cfg_addr == OFF_WIN5 && host_en ? cfg_byte_en : 4'h0,
               win5_mask),
            preload_wdata, preload_addr == OFF_WIN5 && pre_en ? preload_byte_en : 4'h0,
            win5_mask);
      end
   end

   always_ff @(posedge clock or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         subsys <= {SUBSYS_DEVICE_RESET, SUBSYS_VENDOR_RESET};
      end else if (pre_en && preload_addr == OFF_SUBSYS) begin
         subsys <= merge_lanes(subsys, preload_wdata, preload_byte_en, ALL_ONES);
      end
   end

   // link side unless virtual bit or window disable set
   assign rom_active = !rom_window_disable && !rom_virtual_side;

   // 16 KB keeps bit 14 writable
   // 32 KB holds bit 14 read-only
   assign rom_mask = rom_size_32k ? ROM_MASK_32K : ROM_MASK_16K;

   // ROM base; writes land only while the link side owns the window
   always_ff @(posedge clock or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         rom_base <= ROM_BASE_RESET;
      end else if (rom_active && (host_en || pre_en)) begin
         rom_base <= merge_lanes(
            merge_lanes(rom_base, cfg_wdata, cfg_addr == OFF_ROM && host_en ? cfg_byte_en : 4'h0,
               rom_mask),
            preload_wdata, preload_addr == OFF_ROM && pre_en ? preload_byte_en : 4'h0,
            rom_mask);
      end
   end

   // enable bit loads by preload only
   always_ff @(posedge clock or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         rom_enable <= ROM_ENABLE_RESET;
      end else if (rom_active && pre_en && preload_addr == OFF_ROM && preload_byte_en[0]) begin
         rom_enable <= preload_wdata[0];
      end
   end

   // foreign or disabled ROM reads zero
   assign rom_read = rom_active ? ((rom_base & rom_mask) | {31'h0, rom_enable}) : 32'h0;

   always_ff @(posedge clock or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         cap_ptr <= CAP_PTR_RESET;
      end else if (pre_en && preload_addr == OFF_CAP_PTR && preload_byte_en[0]) begin
         cap_ptr <= preload_wdata[7:0];
      end
   end

   always_ff @(posedge clock or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         intr_line <= INTR_LINE_RESET;
      end else if (pre_en && preload_addr == OFF_INTR && preload_byte_en[0]) begin
         intr_line <= preload_wdata[7:0];
      end else if (host_en && cfg_addr == OFF_INTR && cfg_byte_en[0]) begin
         intr_line <= cfg_wdata[7:0];
      end
   end

   // pin accepts 00h or 01h only
   always_ff @(posedge clock or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         intr_pin <= INTR_PIN_RESET;
      end else if (pre_en && preload_addr == OFF_INTR && preload_byte_en[1]) begin
         if (preload_wdata[15:8] == INTR_PIN_NONE || preload_wdata[15:8] == INTR_PIN_RESET) begin
            intr_pin <= preload_wdata[15:8];
         end
      end
   end

   // id, next pointer and capability half
   always_ff @(posedge clock or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         pm_cap <= {PM_CAP_HI_RESET, PM_NEXT_RESET, PM_CAP_ID_RESET};
      end else if (pre_en && preload_addr == OFF_PM_CAP) begin
         pm_cap <= merge_lanes(pm_cap, preload_wdata, preload_byte_en,
            {PM_CAP_HI_LOADABLE, 16'hFFFF});
      end
   end

   // power control dword lives in its own block
   assign pm_acc.host_write = host_en && cfg_addr == OFF_PM_CTRL;
   assign pm_acc.preload_write = pre_en && preload_addr == OFF_PM_CTRL;
   assign pm_acc.byte_en = pm_acc.preload_write ? preload_byte_en : cfg_byte_en;
   assign pm_acc.wdata = pm_acc.preload_write ? preload_wdata : cfg_wdata;

   pm_state_control pm_unit (
      .clock(clock),
      .rst_n(rst_n_sync),
      .clock_enable(clock_enable),
      .acc(pm_acc.target),
      .power_state(power_state)
   );

   // read mux; offsets outside this tail read zero
   always_comb begin
      case (cfg_addr)
         OFF_WIN5: read_word = win5_read;
         OFF_SUBSYS: read_word = subsys;
         OFF_ROM: read_word = rom_read;
         OFF_CAP_PTR: read_word = {24'h0, cap_ptr};
         OFF_INTR: read_word = {16'h0, intr_pin, intr_line};
         OFF_PM_CAP: read_word = pm_cap;
         OFF_PM_CTRL: read_word = pm_acc.rdata;
         default: read_word = 32'h0;
      endcase
   end

   // read answer one cycle after the strobe; data held until next read
   always_ff @(posedge clock or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         cfg_rdata <= 32'h0;
         cfg_read_valid <= 1'b0;
      end else if (clock_enable) begin
         cfg_read_valid <= cfg_read;
         if (cfg_read) begin
            cfg_rdata <= read_word;
         end
      end
   end

   // registered copies for the decoders downstream
   always_ff @(posedge clock or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         upper_window_five <= 32'h0;
         window_pair_64bit <= 1'b0;
         rom_link_enabled <= 1'b0;
         rom_window_mask <= 32'h0;
         rom_window_base <= 32'h0;
         interrupt_line <= INTR_LINE_RESET;
      end else if (clock_enable) begin
         upper_window_five <= win5_read;
         window_pair_64bit <= pair_64;
         // ownership needs both gate and enable
         rom_link_enabled <= rom_active && rom_enable;
         rom_window_mask <= rom_mask;
         rom_window_base <= rom_read & rom_mask;
         interrupt_line <= intr_line;
      end
   end
endmodule
`default_nettype wire

// [rtl/pm_access_if.sv]
// write strobes and read word for the power control dword
// assumes the owner decodes the address before raising a strobe
`timescale 1ns/1ps
`default_nettype none
interface pm_access_if;
   logic host_write;
   logic preload_write;
   logic [3:0] byte_en;
   logic [31:0] wdata;
   logic [31:0] rdata;
   modport decoder (output host_write, output preload_write, output byte_en,
      output wdata, input rdata);
   modport target (input host_write, input preload_write, input byte_en,
      input wdata, output rdata);
endinterface
`default_nettype wire

// [rtl/pm_state_control.sv]
// power state, soft-reset flag and per-select power data
// assumes strobes arrive already decoded for dword 44h
`timescale 1ns/1ps
`default_nettype none
module pm_state_control import nt_cfg_pkg::*; (
   input wire logic clock, // core clock
   input wire logic rst_n, // synchronised reset, active low
   input wire logic clock_enable, // freezes state when low
   pm_access_if.target acc, // decoded access
   output logic [1:0] power_state // current device power state
);
   logic no_soft_reset;
   logic [3:0] data_select;
   logic select_open;
   logic [1:0] scale_mem [4];
   logic [7:0] data_mem [4];
   logic [2:0] rd_slot;
   logic [2:0] wr_slot;

   // maps a select code to {valid, slot}; unsupported codes are invalid
   function automatic logic [2:0] select_slot(input logic [3:0] sel);
      case (sel)
         DSEL_D0_USED: select_slot = 3'h4;
         DSEL_D3_USED: select_slot = 3'h5;
         DSEL_D0_DISS: select_slot = 3'h6;
         DSEL_D3_DISS: select_slot = 3'h7;
         default: select_slot = 3'h0;
      endcase
   endfunction

   assign rd_slot = select_slot(data_select);
   assign wr_slot = select_slot(acc.byte_en[1] ? acc.wdata[12:9] : data_select);

   // power state: unsupported D1/D2 writes are dropped silently
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         power_state <= PS_D0;
      end else if (clock_enable && (acc.host_write || acc.preload_write) && acc.byte_en[0]) begin
         if (acc.wdata[1:0] == PS_D0 || acc.wdata[1:0] == PS_D3HOT) begin
            power_state <= acc.wdata[1:0];
         end
      end
   end

   // select becomes host-writable only after a preload touched it
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         no_soft_reset <= NO_SOFT_RESET_RESET;
         data_select <= DSEL_RESET;
         select_open <= 1'b0;
      end else if (clock_enable) begin
         if (acc.preload_write && acc.byte_en[0]) begin
            no_soft_reset <= acc.wdata[3];
         end
         if (acc.preload_write && acc.byte_en[1]) begin
            data_select <= acc.wdata[12:9];
            select_open <= 1'b1;
         end else if (acc.host_write && acc.byte_en[1] && select_open) begin
            data_select <= acc.wdata[12:9];
         end
      end
   end

   // scale and data tables, loaded by preload only
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < 4; i++) begin
            scale_mem[i] <= SCALE_RESET;
            data_mem[i] <= PM_DATA_RESET;
         end
      end else if (clock_enable && acc.preload_write && wr_slot[2]) begin
         if (acc.byte_en[1]) begin
            scale_mem[wr_slot[1:0]] <= acc.wdata[14:13];
         end
         if (acc.byte_en[3]) begin
            data_mem[wr_slot[1:0]] <= acc.wdata[31:24];
         end
      end
   end

   // control, reserved extension byte, data byte
   assign acc.rdata = {rd_slot[2] ? data_mem[rd_slot[1:0]] : 8'h00, 8'h00, 1'b0,
      rd_slot[2] ? scale_mem[rd_slot[1:0]] : 2'h0, data_select, 1'b0, 4'h0, no_soft_reset,
      1'b0, power_state};
endmodule
`default_nettype wire

// [verification/cfg_host_model.sv]
// host side of the config port: one-cycle strobes, read data taken on the pulse
// assumes callers enter each task just after a rising edge
`timescale 1ns/1ps
`default_nettype none
module cfg_host_model (
   input wire logic clock, // core clock
   output logic cfg_write, // write strobe
   output logic cfg_read, // read strobe
   output logic [7:0] cfg_addr, // address
   output logic [3:0] cfg_byte_en, // lanes
   output logic [31:0] cfg_wdata, // write data
   input wire logic [31:0] cfg_rdata, // read data
   input wire logic cfg_read_valid // read pulse
);
   // idle bus starts at zero; after each task the address shows its inverse so nothing leans on stale lines
   initial begin
      cfg_write = 1'b0;
      cfg_read = 1'b0;
      cfg_addr = 8'h00;
      cfg_byte_en = 4'h0;
      cfg_wdata = 32'h0000_0000;
   end
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      cfg_addr = a;
      cfg_byte_en = 4'hF;
      cfg_wdata = d;
      cfg_write = 1'b1;
      @(posedge clock);
      #1;
      cfg_write = 1'b0;
      cfg_addr = ~a;
      cfg_wdata = ~d;
      @(posedge clock);
      #1;
   endtask
   // the pulse rises on the taking edge itself and is sampled 1 ns after it
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      cfg_addr = a;
      cfg_byte_en = 4'hF;
      cfg_read = 1'b1;
      @(posedge clock);
      #1;
      cfg_read = 1'b0;
      cfg_addr = ~a;
      d = (cfg_read_valid === 1'b1) ? cfg_rdata : 32'hXXXX_XXXX;
      @(posedge clock);
      #1;
   endtask
endmodule
`default_nettype wire

// [verification/nt_link_config_header_tail_checker.sv]
// assertions on the header tail ports: read pulse, window five, ROM, routing
// assumes a bind onto the top module and a single clock domain
`timescale 1ns/1ps
`default_nettype none
module nt_cfg_checker import nt_cfg_pkg::*; (
   input wire logic clock, // core clock
   input wire logic rstn, // reset, active low
   input wire logic clock_enable, // run enable
   input wire logic cfg_write, // host write
   input wire logic cfg_read, // host read
   input wire logic [7:0] cfg_addr, // host address
   input wire logic [3:0] cfg_byte_en, // host lanes
   input wire logic [31:0] cfg_wdata, // host data
   input wire logic [31:0] cfg_rdata, // read data
   input wire logic cfg_read_valid, // read pulse
   input wire logic preload_write, // load strobe
   input wire logic [7:0] preload_addr, // load address
   input wire logic [3:0] preload_byte_en, // load lanes
   input wire logic [1:0] window_four_map_type, // window four type
   input wire logic rom_virtual_side, // ROM on virtual side
   input wire logic rom_window_disable, // ROM off
   input wire logic rom_size_32k, // ROM size
   input wire logic [31:0] upper_window_five, // window five
   input wire logic window_pair_64bit, // pairing flag
   input wire logic rom_link_enabled, // link owns ROM
   input wire logic [31:0] rom_window_mask, // ROM mask
   input wire logic [31:0] rom_window_base, // ROM base
   input wire logic [7:0] interrupt_line // routing byte
);
   logic [1:0] up_cnt;
   wire logic ready;
   // outputs mean nothing until the internal reset copy has let go
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         up_cnt <= 2'h0;
      end else if (clock_enable && up_cnt != 2'h3) begin
         up_cnt <= up_cnt + 2'h1;
      end
   end
   assign ready = (up_cnt == 2'h3);
   default clocking dclk @(posedge clock); endclocking
   default disable iff (!rstn);
   read_pulse_a: assert property (ready && clock_enable && cfg_read |=> cfg_read_valid) else $error("no read pulse");
   pulse_cause_a: assert property (cfg_read_valid |-> $past(cfg_read && clock_enable)) else $error("stray read pulse");
   pair_flag_a: assert property (ready && clock_enable |=> window_pair_64bit == ($past(window_four_map_type) == MAP_TYPE_64)) else $error("pair flag wrong");
   win_low_zero_a: assert property (ready && clock_enable && window_four_map_type != MAP_TYPE_64 |=> upper_window_five[19:0] == 20'h0_0000) else $error("window five low bits set");
   rom_size_mask_a: assert property (ready && clock_enable |=> rom_window_mask == ($past(rom_size_32k) ? ROM_MASK_32K : ROM_MASK_16K)) else $error("ROM mask wrong");
   rom_inactive_a: assert property (ready && clock_enable && (rom_window_disable || rom_virtual_side) |=> !rom_link_enabled && rom_window_base == 32'h0000_0000) else $error("ROM active while off");
   rom_bit_fourteen_a: assert property (ready && clock_enable && cfg_read && cfg_addr == OFF_ROM && rom_size_32k |=> cfg_rdata[14:1] == 14'h0000) else $error("ROM bit 14 or reserved set");
   intr_upper_zero_a: assert property (ready && clock_enable && cfg_read && cfg_addr == OFF_INTR |=> cfg_rdata[31:16] == 16'h0000) else $error("grant or latency nonzero");
   cap_ptr_upper_a: assert property (ready && clock_enable && cfg_read && cfg_addr == OFF_CAP_PTR |=> cfg_rdata[31:8] == 24'h00_0000) else $error("pointer upper bits set");
   line_write_a: assert property (ready && clock_enable && cfg_write && cfg_addr == OFF_INTR && cfg_byte_en[0] && !(preload_write && preload_addr == OFF_INTR && preload_byte_en[0]) ##1 clock_enable |=> interrupt_line == $past(cfg_wdata[7:0], 2)) else $error("routing byte not stored");
endmodule
bind nt_link_config_header_tail nt_cfg_checker checker_inst (.clock, .rstn, .clock_enable, .cfg_write, .cfg_read,
   .cfg_addr, .cfg_byte_en, .cfg_wdata, .cfg_rdata, .cfg_read_valid, .preload_write, .preload_addr, .preload_byte_en,
   .window_four_map_type, .rom_virtual_side, .rom_window_disable, .rom_size_32k, .upper_window_five,
   .window_pair_64bit, .rom_link_enabled, .rom_window_mask, .rom_window_base, .interrupt_line);
`default_nettype wire

// [verification/nt_link_config_header_tail_test.sv]
// self-checking bench for the header tail: rows, then reset, window, ROM, load
// assumes the host model as config master and this bench as the load source
`timescale 1ns/1ps
`default_nettype none
module nt_link_config_header_tail_test import nt_cfg_pkg::*;;
   typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e;} row_s;
   logic clock, rstn, clock_enable, preload_write, cfg_write, cfg_read, cfg_read_valid;
   logic rom_virtual_side, rom_window_disable, rom_size_32k, window_pair_64bit, rom_link_enabled;
   logic [7:0] cfg_addr, preload_addr, interrupt_line;
   logic [3:0] cfg_byte_en, preload_byte_en;
   logic [31:0] cfg_wdata, cfg_rdata, preload_wdata, upper_window_five, rom_window_mask, rom_window_base, rd;
   logic [1:0] window_four_map_type, power_state;
   int err_count = 0;
   int n_compared = 0;
   row_s rows[9];
   cfg_host_model cfg_host_model_inst (.clock(clock), .cfg_write(cfg_write), .cfg_read(cfg_read),
      .cfg_addr(cfg_addr), .cfg_byte_en(cfg_byte_en), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
      .cfg_read_valid(cfg_read_valid));
   nt_link_config_header_tail nt_link_config_header_tail_inst (.clock(clock), .rstn(rstn),
      .clock_enable(clock_enable), .cfg_write(cfg_write), .cfg_read(cfg_read), .cfg_addr(cfg_addr),
      .cfg_byte_en(cfg_byte_en), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_read_valid(cfg_read_valid),
      .preload_write(preload_write), .preload_addr(preload_addr), .preload_byte_en(preload_byte_en),
      .preload_wdata(preload_wdata), .window_four_map_type(window_four_map_type),
      .rom_virtual_side(rom_virtual_side), .rom_window_disable(rom_window_disable), .rom_size_32k(rom_size_32k),
      .upper_window_five(upper_window_five), .window_pair_64bit(window_pair_64bit),
      .rom_link_enabled(rom_link_enabled), .rom_window_mask(rom_window_mask), .rom_window_base(rom_window_base),
      .interrupt_line(interrupt_line), .power_state(power_state));
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
      cfg_host_model_inst.rd(a, rd);
      check(name, rd, exp);
   endtask
   // load path strobe; same one-cycle shape as the host side
   task automatic load(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
      preload_addr = a;
      preload_byte_en = be;
      preload_wdata = d;
      preload_write = 1'b1;
      @(posedge clock);
      #1;
      preload_write = 1'b0;
      preload_wdata = ~d;
      @(posedge clock);
      #1;
   endtask
   task automatic settle();
      repeat (2) @(posedge clock);
      #1;
   endtask
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // watchdog sized well beyond the 120 or so cycles the tests need
   initial begin
      repeat (5000) @(posedge clock);
      err_count++;
      close_out();
   end
   initial begin
      rows = '{'{OFF_WIN5, ALL_ONES, WIN5_UPPER_MASK}, '{OFF_SUBSYS, ALL_ONES, {SUBSYS_DEVICE_RESET, SUBSYS_VENDOR_RESET}},
         '{OFF_ROM, 32'h0000_0000, 32'h0000_0001}, '{OFF_CAP_PTR, ALL_ONES, {24'h00_0000, CAP_PTR_RESET}},
         '{OFF_INTR, ALL_ONES, {16'h0000, INTR_PIN_RESET, 8'hFF}},
         '{OFF_PM_CAP, ALL_ONES, {PM_CAP_HI_RESET, PM_NEXT_RESET, PM_CAP_ID_RESET}},
         '{OFF_PM_CTRL, ALL_ONES, {28'h000_0000, 2'h2, PS_D3HOT}},
         '{OFF_PM_CTRL, 32'h0000_0001, {28'h000_0000, 2'h2, PS_D3HOT}}, '{8'h28, ALL_ONES, 32'h0000_0000}};
      {rstn, clock_enable, preload_write, rom_virtual_side, rom_window_disable, rom_size_32k} = 6'h10;
      {preload_addr, preload_byte_en, preload_wdata, window_four_map_type} = '0;
      repeat (8) @(posedge clock);
      #1;
      rstn = 1'b1;
      settle();
      settle();
      // ordinary cases: write, then read back what the rules leave
      foreach (rows[i]) begin
         cfg_host_model_inst.wr(rows[i].a, rows[i].d);
         rd_chk("row read", rows[i].a, rows[i].e);
      end
      check("power state", {30'h0, power_state}, {30'h0, PS_D3HOT});
      $display("test rows done");
      // second reset in mid-run restores the writable fields
      rstn = 1'b0;
      settle();
      rstn = 1'b1;
      settle();
      settle();
      rd_chk("win5 reset", OFF_WIN5, WIN5_RESET);
      rd_chk("rom reset", OFF_ROM, ROM_BASE_RESET | 32'h1);
      rd_chk("intr reset", OFF_INTR, 32'h0000_0100);
      rd_chk("pm reset", OFF_PM_CTRL, 32'h0000_0008);
      $display("test reset done");
      // window five pairing, then a reserved map code
      window_four_map_type = MAP_TYPE_64;
      settle();
      cfg_host_model_inst.wr(OFF_WIN5, ALL_ONES);
      rd_chk("win5 64", OFF_WIN5, ALL_ONES);
      check("pair flag", {31'h0, window_pair_64bit}, 32'h1);
      window_four_map_type = 2'h1;
      settle();
      rd_chk("win5 resv", OFF_WIN5, WIN5_UPPER_MASK);
      check("win5 port", upper_window_five, WIN5_UPPER_MASK);
      window_four_map_type = MAP_TYPE_32;
      $display("test window done");
      // ROM size, ownership and disable
      rom_size_32k = 1'b1;
      settle();
      rd_chk("rom 32k", OFF_ROM, 32'hFFFF_8001);
      check("rom mask", rom_window_mask, ROM_MASK_32K);
      cfg_host_model_inst.wr(OFF_ROM, 32'h0000_0000);
      rom_size_32k = 1'b0;
      settle();
      rd_chk("rom 16k", OFF_ROM, 32'h0000_4001);
      rom_virtual_side = 1'b1;
      settle();
      rd_chk("rom virt", OFF_ROM, 32'h0000_0000);
      check("rom owner", {31'h0, rom_link_enabled}, 32'h0);
      {rom_virtual_side, rom_window_disable} = 2'h1;
      settle();
      cfg_host_model_inst.wr(OFF_ROM, ALL_ONES);
      rd_chk("rom off", OFF_ROM, 32'h0000_0000);
      rom_window_disable = 1'b0;
      settle();
      rd_chk("rom back", OFF_ROM, 32'h0000_4001);
      check("rom owner", {31'h0, rom_link_enabled}, 32'h1);
      check("rom base", rom_window_base, 32'h0000_4000);
      $display("test rom done");
      // load path: refused pin code, accepted none, subsystem codes
      load(OFF_INTR, 4'h2, 32'h0000_0200);
      rd_chk("pin bad", OFF_INTR, 32'h0000_0100);
      load(OFF_INTR, 4'h2, 32'h0000_0000);
      rd_chk("pin none", OFF_INTR, 32'h0000_0000);
      load(OFF_SUBSYS, 4'hF, 32'h1234_5678);
      rd_chk("subsys load", OFF_SUBSYS, 32'h1234_5678);
      load(OFF_WIN5, 4'hF, 32'h0000_0000);
      rd_chk("win5 load", OFF_WIN5, 32'h0000_0000);
      window_four_map_type = MAP_TYPE_64;
      settle();
      rd_chk("win5 kept", OFF_WIN5, 32'h000F_FFFF);
      window_four_map_type = MAP_TYPE_32;
      // frozen clock enable: the write is not taken
      clock_enable = 1'b0;
      cfg_host_model_inst.wr(OFF_INTR, 32'h0000_0055);
      clock_enable = 1'b1;
      settle();
      check("frozen line", {24'h0, interrupt_line}, 32'h0000_0000);
      $display("test load done");
      close_out();
   end
endmodule
`default_nettype wire
